// file: inc/ass_pkg.sv
// Shared constants and types for the acquisition sample sequencer.
package ass_pkg;
  // Default delay, in sample timebase ticks, from start to first sample.
  localparam int unsigned START_DELAY_DEF = 4;
  // Default counter widths.
  localparam int unsigned CNT_W_DEF = 16;
  localparam int unsigned CHAN_W_DEF = 5;
  // Trigger source selection.
  localparam logic TRIG_SRC_HW = 1'b0;
  localparam logic TRIG_SRC_SW = 1'b1;

  // Sequencer states.
  typedef enum logic [2:0] {
    ASS_IDLE,
    ASS_DELAY,
    ASS_PRE,
    ASS_POST
  } ass_state_e;

  // Acquisition setup held stable by the host while running.
  typedef struct packed {
    logic trig_sw;
    logic pre_en;
    logic int_timing;
    logic [15:0] pre_count;
    logic [15:0] post_count;
    logic [15:0] sample_div;
    logic [15:0] convert_div;
    logic [15:0] start_delay;
    logic [4:0] n_chan;
  } ass_cfg_s;
endpackage

// file: verilog/ass_sequencer.sv
// Acquisition sample sequencer: start trigger, sample and conversion pacing.
`timescale 1ns/1ps
`default_nettype none
module ass_sequencer #(
  parameter int unsigned CNT_W = ass_pkg::CNT_W_DEF,
  parameter int unsigned CHAN_W = ass_pkg::CHAN_W_DEF
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Control from host software.
  input wire ass_pkg::ass_cfg_s cfg_i,
  input wire logic arm_i,
  input wire logic sw_start_i,
  // External sources.
  input wire logic hw_trig_i,
  input wire logic ext_sample_i,
  // Outputs.
  output logic acq_start_trigger_o,
  output logic acq_sample_tick_o,
  output logic channel_conversion_tick_o,
  output logic [CHAN_W-1:0] chan_idx_o,
  output logic busy_o,
  output logic done_o,
  output logic overrun_o
);
  import ass_pkg::*;

  // The struct fixes field widths; wider settings cannot be carried.
  if (CNT_W != 16 || CHAN_W != 5) begin : g_bad_width
    $error("ass_sequencer: CNT_W must be 16 and CHAN_W 5");
  end

  ass_state_e state_ff;
  logic hw_trig_ff;
  logic [CNT_W-1:0] samp_cnt_ff;
  logic [CNT_W-1:0] div_ff;
  logic [CNT_W-1:0] cdiv_ff;
  logic [CHAN_W-1:0] conv_left_ff;
  logic sample_evt;
  logic start_evt;
  logic running;

  // Decrement clamped at zero, used by several counters.
  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
    dec_sat = (v == '0) ? v : v - 1'b1;
  endfunction

  assign running = (state_ff == ASS_PRE) || (state_ff == ASS_POST);
  // Hardware start is a rising edge; software start is a command strobe.
  assign start_evt = (state_ff == ASS_IDLE) && arm_i &&
    (cfg_i.trig_sw ? sw_start_i : (hw_trig_i && !hw_trig_ff));
  // Internal divider reaching zero, or an external tick, makes a sample.
  assign sample_evt = running && (cfg_i.int_timing ?
    (div_ff == '0) : ext_sample_i);

  // Edge detector history for the hardware trigger.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hw_trig_ff <= 1'b0;
    end else begin
      hw_trig_ff <= hw_trig_i;
    end
  end

  // Main sequence: delay, pre-trigger count, post-trigger count.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ASS_IDLE;
      samp_cnt_ff <= '0;
      div_ff <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_ff)
        ASS_IDLE: begin
          if (start_evt) begin
            // Start delay counted in the sample timebase (this clock).
            div_ff <= dec_sat(cfg_i.start_delay);
            samp_cnt_ff <= cfg_i.pre_en ? cfg_i.pre_count
                                        : cfg_i.post_count;
            state_ff <= cfg_i.int_timing ? ASS_DELAY :
              (cfg_i.pre_en ? ASS_PRE : ASS_POST);
          end
        end
        ASS_DELAY: begin
          div_ff <= dec_sat(div_ff);
          if (div_ff == '0) begin
            state_ff <= cfg_i.pre_en ? ASS_PRE : ASS_POST;
          end
        end
        ASS_PRE, ASS_POST: begin
          if (cfg_i.int_timing) begin
            div_ff <= (div_ff == '0) ? dec_sat(cfg_i.sample_div)
                                     : div_ff - 1'b1;
          end
          if (sample_evt) begin
            samp_cnt_ff <= dec_sat(samp_cnt_ff);
            if (samp_cnt_ff <= 16'h0001) begin
              if (state_ff == ASS_PRE) begin
                samp_cnt_ff <= cfg_i.post_count;
                state_ff <= ASS_POST;
              end else begin
                state_ff <= ASS_IDLE;
                done_o <= 1'b1;
              end
            end
          end
        end
        default: state_ff <= ASS_IDLE;
      endcase
    end
  end

  // Output strobes for start and sample, and the busy flag.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acq_start_trigger_o <= 1'b0;
      acq_sample_tick_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      acq_start_trigger_o <= start_evt && cfg_i.trig_sw;
      acq_sample_tick_o <= sample_evt;
      busy_o <= (state_ff != ASS_IDLE) || start_evt;
    end
  end

  // Conversion pacing: one tick per channel, then idle until next sample.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_left_ff <= '0;
      cdiv_ff <= '0;
      chan_idx_o <= '0;
      channel_conversion_tick_o <= 1'b0;
    end else begin
      channel_conversion_tick_o <= 1'b0;
      if (sample_evt) begin
        conv_left_ff <= cfg_i.n_chan;
        cdiv_ff <= dec_sat(cfg_i.convert_div);
        chan_idx_o <= '0;
      end else if (conv_left_ff != '0) begin
        cdiv_ff <= dec_sat(cdiv_ff);
        if (cdiv_ff == '0) begin
          channel_conversion_tick_o <= 1'b1;
          conv_left_ff <= conv_left_ff - 1'b1;
          cdiv_ff <= dec_sat(cfg_i.convert_div);
          if (conv_left_ff != 5'h01) begin
            chan_idx_o <= chan_idx_o + 1'b1;
          end
        end
      end
    end
  end

  // Overrun is sticky until the next acquisition starts.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overrun_o <= 1'b0;
    end else if (sample_evt && conv_left_ff != '0) begin
      overrun_o <= 1'b1;
    end else if (start_evt) begin
      overrun_o <= 1'b0;
    end
  end

  // A done pulse comes only out of post-trigger counting.
  a_done_from_post: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    $rose(done_o) |-> $past(state_ff) == ASS_POST)
    else $error("done without post phase");

  // No sample tick leaves the block while idle.
  a_idle_no_tick: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (state_ff == ASS_IDLE && !done_o) |=> !acq_sample_tick_o)
    else $error("sample tick while idle");

  // Software start pulses the trigger line one cycle later.
  a_sw_start_pulse: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (start_evt && cfg_i.trig_sw) |=> acq_start_trigger_o)
    else $error("software start not pulsed");

  // Hardware starts never pulse the start line.
  a_hw_no_pulse: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    acq_start_trigger_o |-> $past(cfg_i.trig_sw))
    else $error("start pulse on hardware trigger");

  // Overrun follows a sample tick with conversions still due.
  a_overrun_cause: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (sample_evt && conv_left_ff != '0) |=> overrun_o)
    else $error("overrun missed");

  // A sample tick reloads the channel countdown.
  a_chan_reload: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    sample_evt |=> conv_left_ff == $past(cfg_i.n_chan))
    else $error("channel count not loaded");

  // Each sample tick with the count above one decrements the sample counter.
  a_cnt_dec: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (sample_evt && samp_cnt_ff > 16'h0001) |=>
      samp_cnt_ff == $past(samp_cnt_ff) - 16'h0001)
    else $error("sample counter not decremented");

  // Default delay of four cycles before counting begins.
  a_start_delay: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (start_evt && cfg_i.int_timing && cfg_i.start_delay == 16'h0004) |=>
      (state_ff == ASS_DELAY) [*4] ##1 running)
    else $error("start delay wrong");

  // Internal timing with the divider count at one ticks on the next cycle.
  a_sample_rate: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    (running && cfg_i.int_timing && !sample_evt && div_ff == 16'h0001)
      |=> sample_evt || !running)
    else $error("sample pacing wrong");

  // Conversion ticks only while conversions remain.
  a_conv_bounded: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i)
    channel_conversion_tick_o |-> $past(conv_left_ff) != '0)
    else $error("extra conversion tick");
endmodule
`default_nettype wire

// file: tb/ass_far_side.sv
// Model of the external trigger and external sample sources.
`timescale 1ns/1ps
`default_nettype none
module ass_far_side (
  // Clock.
  input wire logic sys_clk_i,
  // Sources.
  output logic hw_trig_o,
  output logic ext_sample_o
);
  initial begin
    hw_trig_o = 1'b0;
    ext_sample_o = 1'b0;
  end

  // The edge is held a few cycles so a slow detector still sees it.
  task automatic trig_edge();
    @(posedge sys_clk_i);
    #1 hw_trig_o = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 hw_trig_o = 1'b0;
  endtask

  // One-cycle sample pulses separated by gap plus one idle cycles.
  task automatic samples(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1 ext_sample_o = 1'b1;
      @(posedge sys_clk_i);
      #1 ext_sample_o = 1'b0;
      repeat (gap) @(posedge sys_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/ai_sample_sequencer_test.sv
// Self-checking bench for the acquisition sample sequencer.
`timescale 1ns/1ps
`default_nettype none
module ai_sample_sequencer_test;
  import ass_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ass_cfg_s cfg = '0;
  logic arm = 1'b1;
  logic sw_start = 1'b0;
  logic hw_trig, ext_smp, start_o, smp_o, conv_o, busy, done, ovr;
  logic [4:0] chan;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_start, n_smp, n_conv, n_done, gap, g1, last, cgap, clast;

  ass_sequencer dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_i(cfg), .arm_i(arm), .sw_start_i(sw_start), .hw_trig_i(hw_trig),
    .ext_sample_i(ext_smp), .acq_start_trigger_o(start_o),
    .acq_sample_tick_o(smp_o), .channel_conversion_tick_o(conv_o),
    .chan_idx_o(chan), .busy_o(busy), .done_o(done), .overrun_o(ovr));
  ass_far_side far_u (.sys_clk_i(sys_clk_i), .hw_trig_o(hw_trig),
    .ext_sample_o(ext_smp));

  // Clock at 10 MHz.
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Event counters, read mid-cycle where outputs are settled.
  // A hang is cut short by the cycle ceiling.
  always @(negedge sys_clk_i) begin
    cyc++;
    if (start_o === 1'b1) last = cyc;
    if (conv_o === 1'b1) begin
      cgap = cyc - clast;
      clast = cyc;
    end
    n_start += (start_o === 1'b1);
    n_conv += (conv_o === 1'b1);
    n_done += (done === 1'b1);
    if (smp_o === 1'b1) begin
      gap = cyc - last;
      if (n_smp == 0) g1 = gap;
      last = cyc;
      n_smp++;
    end
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_cnt(input string what, input int exp, input int got);
    comparisons++;
    if (exp != got) begin
      $display("Error %s expected %0d seen %0d", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (exp !== got) begin
      $display("Error %s expected %b seen %b", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic chk_vec(input string what, input logic [4:0] exp,
    input logic [4:0] got);
    comparisons++;
    if (exp !== got) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  // Loads a setup while idle and clears the counters.
  task automatic setup(input logic sw, input logic pre, input logic it,
    input int pc, input int qc, input int sd, input int cd, input int nc);
    @(posedge sys_clk_i);
    #1 cfg = '0;
    {cfg.trig_sw, cfg.pre_en, cfg.int_timing} = {sw, pre, it};
    {cfg.pre_count, cfg.post_count} = {pc[15:0], qc[15:0]};
    {cfg.sample_div, cfg.convert_div} = {sd[15:0], cd[15:0]};
    cfg.start_delay = 16'h0004;
    cfg.n_chan = nc[4:0];
    {n_start, n_smp, n_conv, n_done, g1} = '0;
  endtask

  task automatic go();
    @(posedge sys_clk_i);
    #1 sw_start = 1'b1;
    @(posedge sys_clk_i);
    #1 sw_start = 1'b0;
  endtask

  // Software start, second start refused during the start delay.
  task automatic t_sw();
    setup(1'b1, 1'b0, 1'b1, 0, 2, 1, 1, 0);
    go();
    go();
    repeat (30) @(posedge sys_clk_i);
    #1 chk_cnt("start pulses", 1, n_start);
    chk_cnt("start to first tick", 5, g1);
    chk_cnt("sample ticks", 2, n_smp);
    chk_cnt("done pulses", 1, n_done);
    chk_bit("busy", 1'b0, busy);
  endtask

  // Hardware edge, pre then post counts, external ticks.
  task automatic t_hw_pre();
    setup(1'b0, 1'b1, 1'b0, 2, 3, 1, 1, 3);
    far_u.samples(1, 3);
    #1 chk_cnt("idle ticks", 0, n_smp);
    far_u.trig_edge();
    far_u.samples(8, 20);
    #1 chk_cnt("sample ticks", 5, n_smp);
    chk_cnt("conversions", 15, n_conv);
    chk_vec("channel index", 5'h02, chan);
    chk_cnt("start pulses", 0, n_start);
    chk_cnt("done pulses", 1, n_done);
    chk_bit("overrun", 1'b0, ovr);
  endtask

  // Internal dividers set sample and conversion spacing.
  // The sample period leaves room for both conversions, so no overrun.
  task automatic t_div();
    setup(1'b1, 1'b0, 1'b1, 0, 3, 5, 2, 2);
    go();
    repeat (40) @(posedge sys_clk_i);
    #1 chk_cnt("tick spacing", 5, gap);
    chk_cnt("conversion spacing", 2, cgap);
    chk_cnt("conversions", 6, n_conv);
    chk_cnt("sample ticks", 3, n_smp);
    chk_bit("overrun", 1'b0, ovr);
  endtask

  // Sample ticks faster than the conversions of a sample.
  task automatic t_ovr();
    setup(1'b1, 1'b0, 1'b0, 0, 3, 1, 4, 4);
    go();
    repeat (8) @(posedge sys_clk_i);
    far_u.samples(3, 1);
    #1 chk_bit("overrun", 1'b1, ovr);
  endtask

  // A new start clears overrun; a mid-run reset clears busy, start and channel outputs.
  task automatic t_rst();
    setup(1'b1, 1'b0, 1'b1, 0, 2, 1, 1, 1);
    go();
    repeat (3) @(posedge sys_clk_i);
    #1 chk_bit("overrun after start", 1'b0, ovr);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk_bit("busy in reset", 1'b0, busy);
    chk_bit("start in reset", 1'b0, start_o);
    chk_vec("channel in reset", 5'h00, chan);
    sys_rst_i = 1'b0;
    go();
    repeat (30) @(posedge sys_clk_i);
    #1 chk_cnt("start pulses", 2, n_start);
    chk_cnt("done pulses", 1, n_done);
  endtask

  task automatic give_verdict();
    $display("Checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios.
  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    t_sw();
    t_hw_pre();
    t_div();
    t_ovr();
    t_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
